// file: rtl/rsvb_builder.sv
// Receive status vector builder: one header entry per accepted frame.
// Assumes frame results come from the MAC on clk; carrier and frame pins are pre-synchronised
// here by two flip-flops each.
`include "rsvb_regs.svh"
module rsvb_builder #(
    parameter int LONG_CYCLES = `RSVB_LONG_CYCLES
) (
    input wire logic clk, // 25 MHz clock.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic ctrlWrite, // Write strobe for control register.
    input wire logic [15:0] ctrlWdata, // Control write data.
    output logic [15:0] ctrlRdata, // Control register read value.
    input wire logic rxActivePin, // Receive channel activity, async.
    input wire logic rxFramePin, // Reception attempt in progress, async.
    input wire logic frameDone, // Frame finished and accepted by filters.
    input wire logic frameDrop, // Frame dropped (buffer full or rejected).
    input wire rsvb_pkg::rsvb_frame_s frameInfo, // Results of finished frame.
    input wire logic [15:0] nextAddr, // Address where next frame starts.
    output logic entryValid, // Header entry available.
    input wire logic entryReady, // Buffer memory takes the entry.
    output rsvb_pkg::rsvb_entry_s entryData, // Next-frame address and vector.
    output logic dropFlag // A drop is pending report in next vector.
);
    // ****************************************
    // Control register
    // ****************************************
    logic [15:0] ctrl_reg;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_reg <= `RSVB_CTRL_RESET;
        end else if (ctrlWrite) begin
            ctrl_reg <= ctrlWdata;
            // Decrement request is a pulse; it never stays set.
            ctrl_reg[`RSVB_CTRL_FRAME_DEC_BIT] <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrlRdata <= 16'h0000;
        end else begin
            ctrlRdata <= ctrl_reg;
        end
    end
    logic rxOn;
    assign rxOn = ctrl_reg[`RSVB_CTRL_RX_ON_BIT];

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] actSync;
    logic [1:0] frmSync;
    logic actPrev;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            actSync <= 2'b00;
            frmSync <= 2'b00;
            actPrev <= 1'b0;
        end else begin
            actSync <= {actSync[0], rxActivePin};
            frmSync <= {frmSync[0], rxFramePin};
            actPrev <= actSync[1];
        end
    end

    // ****************************************
    // Sticky history flags
    // ****************************************
    logic carrier_reg;
    logic ignored_reg;
    logic [31:0] longCount;
    logic takeFrame;
    logic inReady;
    logic actFall;
    logic longHit;
    assign takeFrame = frameDone && rxOn && inReady;
    assign actFall = actPrev && !actSync[1];
    assign longHit = (longCount == LONG_CYCLES[31:0]);
    always_ff @(posedge clk) begin
        if (sys_rst || !frmSync[1]) begin
            longCount <= 32'h0000_0000;
        end else if (!longHit) begin
            longCount <= longCount + 32'h0000_0001;
        end
    end
    // Set wins over the clear that a taken frame applies.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            carrier_reg <= 1'b0;
        end else if (actFall && !frmSync[1]) begin
            carrier_reg <= 1'b1;
        end else if (takeFrame) begin
            carrier_reg <= 1'b0;
        end
    end
    logic dropEvent;
    assign dropEvent = frameDrop || (frameDone && (!rxOn || !inReady)) || longHit;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ignored_reg <= 1'b0;
        end else if (dropEvent) begin
            ignored_reg <= 1'b1;
        end else if (takeFrame) begin
            ignored_reg <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dropFlag <= 1'b0;
        end else begin
            dropFlag <= ignored_reg;
        end
    end

    // ****************************************
    // Vector assembly
    // ****************************************
    logic [47:0] vec;
    always_comb begin
        vec = 48'h0000_0000_0000;
        vec[15:0] = frameInfo.byteCount;
        vec[`RSVB_BIT_UNICAST] = frameInfo.unicastHit;
        vec[`RSVB_BIT_PATTERN] = frameInfo.patternHit;
        vec[`RSVB_BIT_WAKEUP] = frameInfo.wakeupHit;
        vec[`RSVB_BIT_HASH] = frameInfo.hashHit;
        vec[`RSVB_BIT_NOTME] = frameInfo.notMeHit;
        vec[`RSVB_BIT_RUNT] = frameInfo.runtHit;
        vec[`RSVB_BIT_VLAN] = frameInfo.vlanSeen;
        vec[`RSVB_BIT_UNKOP] = frameInfo.controlType && !frameInfo.opcodeKnown;
        vec[`RSVB_BIT_PAUSE] = frameInfo.controlType && frameInfo.pauseOpcode
            && frameInfo.destValid;
        vec[`RSVB_BIT_CTRL] = frameInfo.controlType;
        vec[`RSVB_BIT_DRIBBLE] = (frameInfo.extraBits != 3'h0);
        vec[`RSVB_BIT_BCAST] = frameInfo.broadcastDest;
        vec[`RSVB_BIT_MCAST] = frameInfo.multicastDest;
        vec[`RSVB_BIT_RXOK] = !frameInfo.crcBad && !frameInfo.symbolError;
        vec[`RSVB_BIT_LENRANGE] = (frameInfo.typeLength > `RSVB_MAX_LENGTH);
        vec[`RSVB_BIT_LENCHK] = (frameInfo.typeLength <= `RSVB_MAX_LENGTH)
            && (frameInfo.typeLength != frameInfo.payloadCount);
        vec[`RSVB_BIT_CRCERR] = frameInfo.crcBad;
        vec[`RSVB_BIT_CARRIER] = carrier_reg;
        vec[`RSVB_BIT_IGNORED] = ignored_reg;
    end

    // ****************************************
    // Two-entry output buffer
    // ****************************************
    rsvb_pkg::rsvb_entry_s slot0;
    rsvb_pkg::rsvb_entry_s slot1;
    logic [1:0] fill;
    logic pop;
    assign inReady = (fill != 2'd2);
    assign pop = entryValid && entryReady;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fill <= 2'd0;
        end else begin
            fill <= fill + {1'b0, takeFrame} - {1'b0, pop};
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slot0 <= '0;
            slot1 <= '0;
        end else begin
            if (pop) begin
                slot0 <= slot1;
            end
            if (takeFrame) begin
                if (fill == 2'd0 || (fill == 2'd1 && pop)) begin
                    slot0 <= {nextAddr, vec};
                end else begin
                    slot1 <= {nextAddr, vec};
                end
            end
        end
    end
    // Valid registered from the next fill count; valid and data (slot0, a register) track the buffer head in the same cycle.
    logic [1:0] fillNext;
    assign fillNext = fill + {1'b0, takeFrame} - {1'b0, pop};
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            entryValid <= 1'b0;
        end else begin
            entryValid <= (fillNext != 2'd0);
        end
    end
    assign entryData = slot0;

    // ****************************************
    // Checks
    // ****************************************
    // Copy of the frame results, so that stored fields are held against what came in.
    rsvb_pkg::rsvb_frame_s lastInfo;
    logic [15:0] lastAddr;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lastInfo <= '0;
            lastAddr <= 16'h0000;
        end else begin
            lastInfo <= frameInfo;
            lastAddr <= nextAddr;
        end
    end
    sequence takeIntoEmpty;
        takeFrame && fill == 2'd0;
    endsequence
    sequence refusedFrame;
        frameDone && !takeFrame;
    endsequence
    chk_zero_bits: assert property (@(posedge clk) disable iff (sys_rst)
        entryValid |-> entryData.vector[47:37] == 11'h000 && !entryData.vector[19]
            && !entryData.vector[17])
        else $error("Reserved vector bits not zero.");
    chk_byte_count: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[15:0] == lastInfo.byteCount)
        else $error("Byte count not stored.");
    chk_next_addr: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.nextAddr == lastAddr)
        else $error("Next-frame address not stored.");
    chk_crc_ok: assert property (@(posedge clk) disable iff (sys_rst)
        takeFrame && frameInfo.crcBad |-> !vec[23] && vec[20])
        else $error("CRC flags inconsistent.");
    chk_len_range: assert property (@(posedge clk) disable iff (sys_rst)
        takeFrame && frameInfo.typeLength == 16'h05DD |-> vec[22] && !vec[21])
        else $error("Type field not flagged.");
    chk_pause_frame: assert property (@(posedge clk) disable iff (sys_rst)
        vec[28] |-> vec[27] && !vec[29])
        else $error("Pause flag without control flag.");
    chk_dribble_bits: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_DRIBBLE] == (lastInfo.extraBits != 3'h0))
        else $error("Dribble flag does not follow extra bits.");
    chk_drop_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        frameDrop |=> ignored_reg ##0 vec[16])
        else $error("Drop not remembered.");
    chk_refused_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        refusedFrame |=> ignored_reg)
        else $error("Refused frame not remembered.");
    chk_long_frame: assert property (@(posedge clk) disable iff (sys_rst)
        longHit |=> ignored_reg)
        else $error("Long frame not remembered.");
    chk_carrier_clear: assert property (@(posedge clk) disable iff (sys_rst)
        takeFrame && !(actFall && !frmSync[1]) |=> !carrier_reg)
        else $error("Carrier flag not cleared.");
    chk_carrier_set: assert property (@(posedge clk) disable iff (sys_rst)
        actFall && !frmSync[1] |=> carrier_reg)
        else $error("Carrier event not remembered.");
    chk_buffer_full: assert property (@(posedge clk) disable iff (sys_rst)
        fill == 2'd2 && !pop |=> fill == 2'd2)
        else $error("Full buffer lost an entry.");
    chk_entry_hold: assert property (@(posedge clk) disable iff (sys_rst)
        entryValid && !entryReady |=> entryValid && $stable(entryData))
        else $error("Offered entry changed before it was taken.");
    chk_unicast_bit: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_UNICAST] == lastInfo.unicastHit)
        else $error("Unicast flag not stored.");
    chk_pattern_bit: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_PATTERN] == lastInfo.patternHit)
        else $error("Pattern flag not stored.");
    chk_wakeup_bit: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_WAKEUP] == lastInfo.wakeupHit)
        else $error("Wake-up flag not stored.");
    chk_hash_bit: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_HASH] == lastInfo.hashHit)
        else $error("Hash flag not stored.");
    chk_foreign_dest: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_NOTME] == lastInfo.notMeHit)
        else $error("Foreign destination flag not stored.");
    chk_runt_bit: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_RUNT] == lastInfo.runtHit)
        else $error("Runt flag not stored.");
    chk_vlan_bit: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_VLAN] == lastInfo.vlanSeen)
        else $error("VLAN flag not stored.");
    chk_unknown_opcode: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_UNKOP]
            == (lastInfo.controlType && !lastInfo.opcodeKnown))
        else $error("Unknown opcode flag wrong.");
    chk_pause_stored: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_PAUSE]
            == (lastInfo.controlType && lastInfo.pauseOpcode && lastInfo.destValid))
        else $error("Pause flag wrong.");
    chk_control_type: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_CTRL] == lastInfo.controlType)
        else $error("Control frame flag not stored.");
    chk_broadcast_bit: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_BCAST] == lastInfo.broadcastDest)
        else $error("Broadcast flag not stored.");
    chk_multicast_bit: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_MCAST] == lastInfo.multicastDest)
        else $error("Multicast flag not stored.");
    chk_rx_good: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_RXOK]
            == (!lastInfo.crcBad && !lastInfo.symbolError))
        else $error("Received-good flag wrong.");
    chk_length_error: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_LENCHK]
            == (lastInfo.typeLength <= `RSVB_MAX_LENGTH
            && lastInfo.typeLength != lastInfo.payloadCount))
        else $error("Length check flag wrong.");
    chk_crc_error: assert property (@(posedge clk) disable iff (sys_rst)
        takeIntoEmpty |=> entryData.vector[`RSVB_BIT_CRCERR] == lastInfo.crcBad)
        else $error("CRC error flag not stored.");
endmodule : rsvb_builder

// file: rtl/rsvb_regs.svh
// Constants for the receive status vector builder: vector field positions and control bits.
// Assumes inclusion by bare name from the design module.
`ifndef RSVB_REGS_SVH
`define RSVB_REGS_SVH
`define RSVB_CTRL_RESET 16'h0000
`define RSVB_CTRL_RX_ON_BIT 0
`define RSVB_CTRL_FRAME_DEC_BIT 8
`define RSVB_BIT_UNICAST 36
`define RSVB_BIT_PATTERN 35
`define RSVB_BIT_WAKEUP 34
`define RSVB_BIT_HASH 33
`define RSVB_BIT_NOTME 32
`define RSVB_BIT_RUNT 31
`define RSVB_BIT_VLAN 30
`define RSVB_BIT_UNKOP 29
`define RSVB_BIT_PAUSE 28
`define RSVB_BIT_CTRL 27
`define RSVB_BIT_DRIBBLE 26
`define RSVB_BIT_BCAST 25
`define RSVB_BIT_MCAST 24
`define RSVB_BIT_RXOK 23
`define RSVB_BIT_LENRANGE 22
`define RSVB_BIT_LENCHK 21
`define RSVB_BIT_CRCERR 20
`define RSVB_BIT_CARRIER 18
`define RSVB_BIT_IGNORED 16
`define RSVB_MAX_LENGTH 16'h05DC
`define RSVB_LONG_BITS 50000
`define RSVB_CLK_HZ 25000000
`define RSVB_BIT_HZ 10000000
`define RSVB_LONG_CYCLES ((`RSVB_LONG_BITS * (`RSVB_CLK_HZ / 1000)) / (`RSVB_BIT_HZ / 1000))
`endif

// file: rtl/rsvb_pkg.sv
// Types shared by the receive status vector builder.
// Assumes rsvb_regs.svh is on the include path.
package rsvb_pkg;
    // Per-frame results handed over by the MAC and filters at frame end.
    typedef struct packed {
        logic [15:0] byteCount;
        logic [15:0] typeLength;
        logic [15:0] payloadCount;
        logic unicastHit;
        logic patternHit;
        logic wakeupHit;
        logic hashHit;
        logic notMeHit;
        logic runtHit;
        logic vlanSeen;
        logic controlType;
        logic opcodeKnown;
        logic pauseOpcode;
        logic destValid;
        logic broadcastDest;
        logic multicastDest;
        logic crcBad;
        logic symbolError;
        logic [2:0] extraBits;
    } rsvb_frame_s;
    // Word written to buffer memory: next-frame address then the vector.
    typedef struct packed {
        logic [15:0] nextAddr;
        logic [47:0] vector;
    } rsvb_entry_s;
    typedef enum logic [1:0] {
        RSVB_IDLE = 2'b00,
        RSVB_FRAME = 2'b01,
        RSVB_DROP = 2'b10
    } rsvb_state_e;
endpackage : rsvb_pkg

// file: dv/rsvb_mem_model.sv
// Model of the buffer memory that takes header entries from the builder.
// Assumes the builder's clock; stall comes from the bench.
module rsvb_mem_model (
    input wire logic clk, // Shared clock.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic stall, // Holds off taking entries.
    input wire logic entryValid, // Entry offered.
    output logic entryReady, // Memory takes the entry.
    input wire rsvb_pkg::rsvb_entry_s entryData // Offered entry.
);
    rsvb_pkg::rsvb_entry_s taken[$];
    always @(negedge clk) begin
        entryReady <= !stall && !sys_rst;
    end
    always @(posedge clk) begin
        if (!sys_rst && entryValid && entryReady) begin
            taken.push_back(entryData);
        end
    end
endmodule : rsvb_mem_model

// file: dv/rsvb_builder_tb.sv
// Self-checking bench for the receive status vector builder.
// Assumes rsvb_pkg and the memory model are compiled first.
module rsvb_builder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, ctrlWrite, rxActivePin, rxFramePin, frameDone, frameDrop;
    logic entryValid, entryReady, dropFlag, stall, carr, ign;
    logic [15:0] ctrlWdata, ctrlRdata, nextAddr;
    rsvb_pkg::rsvb_frame_s frameInfo;
    rsvb_pkg::rsvb_entry_s entryData;
    logic [63:0] expQ[$];
    int nErrors, nCompared, cycles;
    rsvb_builder #(.LONG_CYCLES(20)) dut (.clk(clk), .sys_rst(sys_rst),
        .ctrlWrite(ctrlWrite), .ctrlWdata(ctrlWdata), .ctrlRdata(ctrlRdata),
        .rxActivePin(rxActivePin), .rxFramePin(rxFramePin), .frameDone(frameDone),
        .frameDrop(frameDrop), .frameInfo(frameInfo), .nextAddr(nextAddr),
        .entryValid(entryValid), .entryReady(entryReady), .entryData(entryData),
        .dropFlag(dropFlag));
    rsvb_mem_model mem (.clk(clk), .sys_rst(sys_rst), .stall(stall),
        .entryValid(entryValid), .entryReady(entryReady), .entryData(entryData));
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic rsvb_pkg::rsvb_frame_s mkFrame(int k);
        rsvb_pkg::rsvb_frame_s f;
        logic [17:0] flags[5] = '{18'h00000, 18'h3F800, 18'h007A0, 18'h004D7, 18'h00009};
        logic [15:0] tl[5] = '{16'h0010, 16'h0800, 16'h8808, 16'h05DC, 16'h05DD};
        f = '0;
        f[17:0] = flags[k];
        f.byteCount = 16'h0040 + 16'(k);
        f.typeLength = tl[k];
        f.payloadCount = 16'h0010;
        return f;
    endfunction : mkFrame
    function automatic logic [47:0] expVec(rsvb_pkg::rsvb_frame_s f);
        logic [47:0] v;
        v = '0;
        v[15:0] = f.byteCount;
        v[36] = f.unicastHit;
        v[35] = f.patternHit;
        v[34] = f.wakeupHit;
        v[33] = f.hashHit;
        v[32] = f.notMeHit;
        v[31] = f.runtHit;
        v[30] = f.vlanSeen;
        v[29] = f.controlType && !f.opcodeKnown;
        v[28] = f.controlType && f.pauseOpcode && f.destValid;
        v[27] = f.controlType;
        v[26] = f.extraBits != 3'h0;
        v[25] = f.broadcastDest;
        v[24] = f.multicastDest;
        v[23] = !f.crcBad && !f.symbolError;
        v[22] = f.typeLength > 16'h05DC;
        v[21] = f.typeLength <= 16'h05DC && f.typeLength != f.payloadCount;
        v[20] = f.crcBad;
        v[18] = carr;
        v[16] = ign;
        return v;
    endfunction : expVec
    task automatic check(logic [63:0] got, logic [63:0] exp);
        nCompared++;
        if (got !== exp) begin
            nErrors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic conclude;
        if (nErrors == 0 && nCompared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic frames(int k0, int n, int nTaken);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            frameDone = 1'b1;
            frameInfo = mkFrame(k0 + i);
            nextAddr = 16'h0200 + 16'(k0 + i);
            if (i < nTaken) begin
                expQ.push_back({nextAddr, expVec(frameInfo)});
                carr = 1'b0;
                ign = 1'b0;
            end else begin
                ign = 1'b1;
            end
        end
        @(negedge clk);
        frameDone = 1'b0;
    endtask : frames
    task automatic drain;
        int t;
        while (expQ.size() > 0) begin
            t = 0;
            while (mem.taken.size() == 0 && t < 50) begin
                @(negedge clk);
                t++;
            end
            if (mem.taken.size() > 0) begin
                check(mem.taken.pop_front(), expQ.pop_front());
            end else begin
                check(64'h0, expQ.pop_front());
            end
        end
    endtask : drain
    // ************************************************************
    // Stimulus
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            nErrors++;
            conclude();
        end
    end
    initial begin
        {ctrlWrite, rxActivePin, rxFramePin, frameDone, frameDrop, stall} = '0;
        {carr, ign, ctrlWdata, nextAddr, cycles, nErrors, nCompared} = '0;
        frameInfo = '0;
        sys_rst = 1'b1;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        check({ctrlRdata, 15'h0, entryValid}, 64'h0);
        frames(0, 1, 0);
        @(negedge clk);
        ctrlWrite = 1'b1;
        ctrlWdata = 16'h0101;
        @(negedge clk);
        ctrlWrite = 1'b0;
        @(negedge clk);
        check(ctrlRdata, 16'h0001);
        for (int k = 0; k < 5; k++) begin
            frames(k, 1, 1);
            drain();
        end
        stall = 1'b1;
        frames(1, 3, 2);
        repeat (3) @(negedge clk);
        check(dropFlag, 1'b1);
        stall = 1'b0;
        drain();
        frames(3, 1, 1);
        drain();
        rxActivePin = 1'b1;
        repeat (5) @(negedge clk);
        rxActivePin = 1'b0;
        repeat (5) @(negedge clk);
        carr = 1'b1;
        frames(4, 1, 1);
        drain();
        rxFramePin = 1'b1;
        repeat (30) @(negedge clk);
        rxFramePin = 1'b0;
        repeat (5) @(negedge clk);
        ign = 1'b1;
        frames(0, 1, 1);
        drain();
        frameDrop = 1'b1;
        @(negedge clk);
        frameDrop = 1'b0;
        ign = 1'b1;
        frames(2, 1, 1);
        drain();
        repeat (5) @(negedge clk);
        check(64'(mem.taken.size()), 64'h0);
        conclude();
    end
endmodule : rsvb_builder_tb
